// ---- inc/lors_defines.svh ----
// Register offsets, reset values and field positions of the OR/subtract ALU.
`ifndef LORS_DEFINES_SVH
`define LORS_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LORS_OFF_FIRST 5'h00
`define LORS_OFF_SHSRC 5'h04
`define LORS_OFF_SHAMT 5'h08
`define LORS_OFF_CTRL 5'h0c
`define LORS_OFF_EXEC 5'h10
`define LORS_OFF_RESULT 5'h14
`define LORS_OFF_PSW 5'h18

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define LORS_CTRL_RST 32'h0000_0000
`define LORS_PSW_RST 32'h0000_0000
`define LORS_SHAMT_LSB 0
`define LORS_SHAMT_MSB 7

`endif

// ---- inc/lors_pkg.sv ----
// Types shared by the OR/subtract ALU.
package lors_pkg;

  typedef enum logic [1:0] {
    bitwise_or_op = 2'b00,
    reverse_subtract_op = 2'b01,
    reverse_subtract_borrow_op = 2'b10,
    subtract_borrow_op = 2'b11
  } lors_op_t;

  // The arithmetic left shift shares the logical left code.
  typedef enum logic [1:0] {
    logical_left_shift = 2'b00,
    logical_right_shift = 2'b01,
    arith_right_shift = 2'b10,
    rotate_right_shift = 2'b11
  } lors_shift_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic rotate_through_carry;
    logic [4:0] shift_imm;
    logic shift_by_reg;
    lors_shift_t shift_kind;
    logic [3:0] imm_rot;
    logic [7:0] imm8;
    logic imm_sel;
    logic set_flags;
    lors_op_t op;
  } lors_ctrl_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic [25:0] rsvd;
    logic [1:0] mode;
  } lors_psw_t;

endpackage

// ---- rtl/lors_alu.sv ----
// OR and reverse/borrow subtract ALU slice with an Avalon-MM register port.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "lors_defines.svh"
// Operation
// - OR sets each of 32 result bits when either operand bit is one.
// - Logical results are formed per bit with no carry between bits.
// - OR never alters the V and mode status bits; only the status write path does.
// - Outside status writes, flags change only when the set-flags bit is given.
// - Immediate operand is an 8-bit constant rotated within 32 bits.
// - Register-sourced shift counts 1 through 255 are served.
// - Constant shift counts 1 through 31 are served.
// - Shifter offers left, logical right, arith right, rotate, carry rotate.
// - Reverse subtract gives second operand minus first register.
// - Reverse borrow subtract gives second minus first minus one plus carry.
// - Borrow subtract takes one more off when carry was clear.
// - Carry in subtraction is an inverted borrow.
// - Carry chaining gives correct multi-word differences.
module lors_alu #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [DATA_W-1:0] alu_result,
  output lors_pkg::lors_psw_t alu_status
);

  if (DATA_W != 32 || ADDR_W < 5) begin : g_param_chk
    $error("Datapath must be 32 bits and address at least 5 bits.");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [31:0] lors_ror(input logic [31:0] val,
                                           input logic [4:0] r);
    lors_ror = (val >> r) | (val << (6'd32 - {1'b0, r}));
  endfunction

  function automatic logic [32:0] lors_shift(input logic [31:0] val,
                                             input logic [7:0] amt,
                                             input lors_pkg::lors_shift_t k,
                                             input logic cin);
    logic [32:0] w;
    logic [31:0] rr;
    w = '0;
    rr = lors_ror(val, amt[4:0]);
    if (amt == 8'h00) begin
      lors_shift = {cin, val};
    end else begin
      case (k)
        lors_pkg::logical_left_shift: begin
          w = {1'b0, val} << amt;
          lors_shift = {w[32], val << amt};
        end
        lors_pkg::logical_right_shift: begin
          w = {val, 1'b0} >> amt;
          lors_shift = {w[0], val >> amt};
        end
        lors_pkg::arith_right_shift: begin
          w = 33'($signed({val, 1'b0}) >>> amt);
          lors_shift = {w[0], w[32:1]};
        end
        default: begin
          lors_shift = {rr[31], rr};
        end
      endcase
    end
  endfunction

  function automatic logic [33:0] lors_add(input logic [31:0] x,
                                           input logic [31:0] y,
                                           input logic ci);
    logic [32:0] s;
    s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
    lors_add = {s[32], (x[31] == y[31]) && (s[31] != x[31]), s[31:0]};
  endfunction

  function automatic logic [31:0] lors_be(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    lors_be = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        lors_be[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic ack_r;
  logic take;
  logic exec;
  logic [31:0] first_r;
  logic [31:0] shsrc_r;
  logic [31:0] shamt_r;
  lors_pkg::lors_ctrl_t ctrl_r;
  lors_pkg::lors_psw_t psw_r;
  logic [31:0] result_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_nxt;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign take = (avs_read | avs_write) & ack_r;
  assign exec = take & avs_write & (avs_address == `LORS_OFF_EXEC);
  assign avs_readdata = rdata_r;

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_comb begin
    if (avs_address == `LORS_OFF_FIRST) begin
      rd_nxt = first_r;
    end else if (avs_address == `LORS_OFF_SHSRC) begin
      rd_nxt = shsrc_r;
    end else if (avs_address == `LORS_OFF_SHAMT) begin
      rd_nxt = shamt_r;
    end else if (avs_address == `LORS_OFF_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (avs_address == `LORS_OFF_RESULT) begin
      rd_nxt = result_r;
    end else if (avs_address == `LORS_OFF_PSW) begin
      rd_nxt = psw_r;
    end else begin
      rd_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      rdata_r <= rd_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      first_r <= 32'h0000_0000;
      shsrc_r <= 32'h0000_0000;
      shamt_r <= 32'h0000_0000;
      ctrl_r <= `LORS_CTRL_RST;
    end else if (take & avs_write) begin
      if (avs_address == `LORS_OFF_FIRST) begin
        first_r <= lors_be(first_r, avs_writedata, avs_byteenable);
      end else if (avs_address == `LORS_OFF_SHSRC) begin
        shsrc_r <= lors_be(shsrc_r, avs_writedata, avs_byteenable);
      end else if (avs_address == `LORS_OFF_SHAMT) begin
        shamt_r <= lors_be(shamt_r, avs_writedata, avs_byteenable);
      end else if (avs_address == `LORS_OFF_CTRL) begin
        ctrl_r <= lors_be(ctrl_r, avs_writedata, avs_byteenable);
      end
    end
  end

  // ****************************************************************
  // Operand shifter
  // ****************************************************************
  logic [7:0] sh_amt;
  logic [32:0] sh_out;
  logic [31:0] second_operand;
  logic sh_carry;
  logic [31:0] imm_val;

  always_comb begin
    if (ctrl_r.shift_by_reg) begin
      sh_amt = shamt_r[`LORS_SHAMT_MSB:`LORS_SHAMT_LSB];
    end else begin
      sh_amt = {3'b000, ctrl_r.shift_imm};
    end
    sh_out = lors_shift(shsrc_r, sh_amt, ctrl_r.shift_kind, psw_r.c);
    imm_val = lors_ror({24'h00_0000, ctrl_r.imm8}, {ctrl_r.imm_rot, 1'b0});
    if (ctrl_r.imm_sel) begin
      second_operand = imm_val;
      sh_carry = (ctrl_r.imm_rot == 4'h0) ? psw_r.c : imm_val[31];
    end else if (ctrl_r.rotate_through_carry) begin
      second_operand = {psw_r.c, shsrc_r[31:1]};
      sh_carry = shsrc_r[0];
    end else begin
      second_operand = sh_out[31:0];
      sh_carry = sh_out[32];
    end
  end

  // ****************************************************************
  // Arithmetic and logic
  // ****************************************************************
  logic [33:0] alu_out;

  always_comb begin
    case (ctrl_r.op)
      lors_pkg::bitwise_or_op: begin
        alu_out = {sh_carry, 1'b0, first_r | second_operand};
      end
      lors_pkg::reverse_subtract_op: begin
        alu_out = lors_add(second_operand, ~first_r, 1'b1);
      end
      lors_pkg::reverse_subtract_borrow_op: begin
        alu_out = lors_add(second_operand, ~first_r, psw_r.c);
      end
      default: begin
        alu_out = lors_add(first_r, ~second_operand, psw_r.c);
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_r <= 32'h0000_0000;
    end else if (exec) begin
      result_r <= alu_out[31:0];
    end
  end

  // ****************************************************************
  // Status word
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      psw_r <= `LORS_PSW_RST;
    end else if (take & avs_write & (avs_address == `LORS_OFF_PSW)) begin
      psw_r <= lors_be(psw_r, avs_writedata, avs_byteenable);
    end else if (exec & ctrl_r.set_flags) begin
      psw_r.n <= alu_out[31];
      psw_r.z <= (alu_out[31:0] == 32'h0000_0000);
      psw_r.c <= alu_out[33];
      if (ctrl_r.op != lors_pkg::bitwise_or_op) begin
        psw_r.v <= alu_out[32];
      end
    end
  end

  assign alu_result = result_r;
  assign alu_status = psw_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_r);

  logic is_or;
  assign is_or = (ctrl_r.op == lors_pkg::bitwise_or_op);

  logic reg_full_shift;
  assign reg_full_shift = ctrl_r.shift_by_reg & ~ctrl_r.imm_sel
    & ~ctrl_r.rotate_through_carry & (sh_amt == 8'h20)
    & (ctrl_r.shift_kind == lors_pkg::logical_left_shift
    || ctrl_r.shift_kind == lors_pkg::logical_right_shift);

  logic imm_shift_31;
  assign imm_shift_31 = ~ctrl_r.shift_by_reg & ~ctrl_r.imm_sel
    & ~ctrl_r.rotate_through_carry & (ctrl_r.shift_imm == 5'h1f)
    & (ctrl_r.shift_kind == lors_pkg::logical_left_shift);

  a_or_result: assert property (exec & is_or |=>
    result_r == ($past(first_r) | $past(second_operand)))
    else $error("OR result wrong.");
  a_or_no_carry: assert property (exec & is_or |=>
    (result_r & ~($past(first_r) | $past(second_operand))) == 32'h0)
    else $error("OR result has extra bits.");
  a_or_status_kept: assert property (exec & is_or |=>
    psw_r.v == $past(psw_r.v) && psw_r.mode == $past(psw_r.mode))
    else $error("OR changed status bits.");
  a_flags_held: assert property (exec & ~ctrl_r.set_flags |=>
    $stable(psw_r))
    else $error("Flags changed without set-flags.");
  a_imm_form: assert property (exec & is_or & ctrl_r.imm_sel |=>
    result_r == ($past(first_r) | lors_ror({24'h0, $past(ctrl_r.imm8)},
    {$past(ctrl_r.imm_rot), 1'b0})))
    else $error("Immediate operand wrong.");
  a_rsb_value: assert property (exec & ctrl_r.op ==
    lors_pkg::reverse_subtract_op |=>
    result_r == $past(second_operand) - $past(first_r))
    else $error("Reverse subtract wrong.");
  a_rsc_value: assert property (exec & ctrl_r.op ==
    lors_pkg::reverse_subtract_borrow_op |=>
    result_r == $past(second_operand) - $past(first_r) - 32'h1
    + {31'h0, $past(psw_r.c)})
    else $error("Reverse borrow subtract wrong.");
  a_sbc_value: assert property (exec & ctrl_r.op ==
    lors_pkg::subtract_borrow_op |=>
    result_r == $past(first_r) - $past(second_operand)
    - {31'h0, ~$past(psw_r.c)})
    else $error("Borrow subtract wrong.");
  a_sub_carry: assert property (exec & ctrl_r.set_flags &
    ctrl_r.op == lors_pkg::reverse_subtract_op |=>
    psw_r.c == ($past(second_operand) >= $past(first_r)))
    else $error("Subtract carry wrong.");
  a_bus_answer: assert property ((avs_read | avs_write) & ~ack_r |=>
    ~avs_waitrequest)
    else $error("Bus answer late.");
  a_or_flags: assert property (exec & is_or & ctrl_r.set_flags |=>
    psw_r.n == result_r[31] && psw_r.z == (result_r == 32'h0000_0000)
    && psw_r.c == $past(sh_carry))
    else $error("Logical flags wrong.");
  a_sbc_carry: assert property (exec & ctrl_r.set_flags &
    ctrl_r.op == lors_pkg::subtract_borrow_op |=>
    psw_r.c == ({1'b0, $past(first_r)} >= {1'b0, $past(second_operand)}
    + {32'h0000_0000, ~$past(psw_r.c)}))
    else $error("Borrow subtract carry wrong.");
  a_rsb_overflow: assert property (exec & ctrl_r.set_flags &
    ctrl_r.op == lors_pkg::reverse_subtract_op |=>
    psw_r.v == ($past(second_operand[31]) != $past(first_r[31])
    && result_r[31] != $past(second_operand[31])))
    else $error("Reverse subtract overflow wrong.");
  a_reg_shift_32: assert property (exec & is_or & reg_full_shift |=>
    result_r == $past(first_r))
    else $error("Register shift by 32 wrong.");
  a_const_shift: assert property (exec & is_or & imm_shift_31 |=>
    result_r == ($past(first_r) | {$past(shsrc_r[0]), 31'h0000_0000}))
    else $error("Constant shift by 31 wrong.");

  c_or_flags: cover property (exec & is_or & ctrl_r.set_flags);
  c_rsc_exec: cover property (exec & ctrl_r.op ==
    lors_pkg::reverse_subtract_borrow_op);
  c_shift_32: cover property (exec & ctrl_r.shift_by_reg &
    sh_amt == 8'd32);
  c_rrx_exec: cover property (exec & ctrl_r.rotate_through_carry);
  c_sbc_borrow: cover property (exec & ~psw_r.c &
    ctrl_r.op == lors_pkg::subtract_borrow_op);

endmodule // lors_alu

// ---- tb/lors_host.sv ----
// Register-bus master standing in for the decoder and register file.
`timescale 1ns/10ps
module lors_host (
  input wire logic sys_clk,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end
  // One access; the idle edge at the end keeps requests apart.
  task automatic xfer(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0000_0000;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata;
      end
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule // lors_host

// ---- tb/tb_logic_or_reverse_subtract_alu.sv ----
// Self-checking bench for the OR and reverse/borrow subtract ALU.
`timescale 1ns/10ps
`include "lors_defines.svh"
module tb_logic_or_reverse_subtract_alu;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] alu_result;
  lors_pkg::lors_psw_t alu_status;
  lors_pkg::lors_psw_t exp_psw;
  logic [31:0] q;
  logic [31:0] lo;
  logic ok;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2 sys_clk = ~sys_clk;
  lors_host host (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  lors_alu dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alu_result(alu_result),
    .alu_status(alu_status));
  // ****************************************************************
  // Reporting and bus access
  // ****************************************************************
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q, ok);
    if (!ok) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // ****************************************************************
  // Reference model
  // ****************************************************************
  function automatic logic [31:0] op2(input logic [31:0] sh,
      input logic [7:0] amt, input logic [31:0] c, input logic cin,
      output logic co);
    logic [63:0] t;
    logic [7:0] a;
    a = c[18] ? amt : {3'h0, c[23:19]};
    co = cin;
    if (c[3]) begin
      t = {2{24'h0, c[11:4]}} >> {c[15:12], 1'b0};
      if (c[15:12] != 4'h0) co = t[31];
      return t[31:0];
    end
    if (c[24]) begin
      co = sh[0];
      return {cin, sh[31:1]};
    end
    if (a == 8'h00) return sh;
    case (c[17:16])
      2'b00: t = {32'h0, sh} << a;
      2'b01: t = {sh, 32'h0} >> a;
      2'b10: t = $signed({sh, 32'h0}) >>> a;
      default: t = {sh, sh} >> a[4:0];
    endcase
    if (c[16] ^ c[17]) begin
      co = t[31];
      return t[63:32];
    end
    co = c[16] ? t[31] : t[32];
    return t[31:0];
  endfunction
  function automatic logic [31:0] mk(input logic [1:0] op, input logic sf,
      input logic [1:0] kind, input logic by);
    return {7'h00, 1'b0, 5'h1f, by, kind, 12'h000, 1'b0, sf, op};
  endfunction
  task automatic run(input logic [31:0] f, input logic [31:0] s,
      input logic [7:0] amt, input logic [31:0] c);
    logic [31:0] v;
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] sum;
    logic co;
    v = op2(s, amt, c, exp_psw.c, co);
    a = (c[1:0] == 2'b11) ? f : v;
    b = (c[1:0] == 2'b11) ? ~v : ~f;
    sum = {1'b0, a} + {1'b0, b} + {32'h0, (c[1:0] == 2'b01) | exp_psw.c};
    if (c[1:0] == 2'b00) sum = {co, f | v};
    if (c[2]) begin
      exp_psw.n = sum[31];
      exp_psw.z = (sum[31:0] == 32'h0);
      exp_psw.c = sum[32];
      if (c[1:0] != 2'b00) exp_psw.v = (a[31] == b[31]) && (sum[31] != a[31]);
    end
    bus(1'b1, `LORS_OFF_FIRST, f);
    bus(1'b1, `LORS_OFF_SHSRC, s);
    bus(1'b1, `LORS_OFF_SHAMT, {24'h0, amt});
    bus(1'b1, `LORS_OFF_CTRL, c);
    bus(1'b1, `LORS_OFF_EXEC, 32'h0);
    bus(1'b0, `LORS_OFF_RESULT, 32'h0);
    check(q, sum[31:0]);
    check(alu_result, sum[31:0]);
    bus(1'b0, `LORS_OFF_PSW, 32'h0);
    check(q, exp_psw);
    check(alu_status, exp_psw);
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    exp_psw = `LORS_PSW_RST;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 5'h0c + 5'(i * 4), 32'h0);
      check(q, 32'h0000_0000);
    end
    for (int op = 0; op < 4; op++) begin
      for (int k = 0; k < 4; k++) begin
        run(32'h8000_0001 + 32'(op), 32'hc000_0003 + 32'(k << 8), 8'h20,
          mk(op[1:0], 1'b1, k[1:0], k[0]));
      end
      run(32'h0000_00ff, 32'h8000_0001, 8'h00, 32'h0100_0004 | 32'(op));
    end
    run(32'h1234_5678, 32'h0f0f_0f0f, 8'h04, mk(2'b11, 1'b0, 2'b01, 1'b1));
    run(32'h4100_0041, 32'h0, 8'h00, {16'h0, 4'h0, 8'h20, 4'b1100});
    run(32'h0000_0005, 32'h0, 8'h00, {16'h0, 4'h4, 8'hea, 4'b1101});
    bus(1'b1, `LORS_OFF_PSW, 32'h0000_0003);
    exp_psw = 32'h0000_0003;
    run(32'h0000_0000, 32'h0, 8'h00, mk(2'b00, 1'b1, 2'b00, 1'b0));
    run(32'h0000_0002, 32'h0, 8'h00, {16'h0, 4'h0, 8'h00, 4'b1101});
    lo = alu_result;
    run(32'h0000_0001, 32'h0, 8'h00, {16'h0, 4'h5, 8'hff, 4'b1110});
    check(lo, 32'hffff_fffe);
    check(alu_result, 32'h3fbf_fffe);
    bus(1'b1, `LORS_OFF_PSW, 32'h0);
    exp_psw = 32'h0;
    run(32'h0000_0010, 32'h3, 8'h00, mk(2'b11, 1'b1, 2'b00, 1'b1));
    check(alu_result, 32'h0000_000c);
    run(32'h0, 32'h8000_0003, 8'h01, mk(2'b00, 1'b1, 2'b00, 1'b1));
    check(alu_result, 32'h0000_0006);
    stop_test();
  end
endmodule // tb_logic_or_reverse_subtract_alu
